/* apcfg_map.vh */
/*
 * Register offsets, field positions, reset values and code points for the
 * analog PLL configuration register block.
 * Assumes an APB slave with 32-bit data and one register per aligned word.
 */
`ifndef APCFG_MAP_VH
`define APCFG_MAP_VH

// Behaviour
// RULE_01: Divider two runs: global on, enable, no bypass.
// RULE_02: Bypass bit steers output mux after divider two.
// RULE_03: Bits 7:4 set divider two ratio.
// RULE_04: Bits 3:0 set divider one ratio.
// RULE_05: External mode: pin low primary, high alternate.
// RULE_06: Alternate field ignored without external mode.
// RULE_07: Alternate field drives both input muxes.
// RULE_08: Codes 000-011 feed crystal or inputs.
// RULE_09: Code 110 DPLL plus crystal; 111 no bypass.
// RULE_10: Software keeps bypass zero without bypass signal.
// RULE_11: Code 100 DPLL plus input one; 101 none.
// RULE_12: Pattern 0xx feeds APLL directly; DPLL off.
// RULE_13: Each decrement source edge steps phase down.
// RULE_14: Decrement source: bit or pins zero-three.
// RULE_15: Each increment source edge steps phase up.
// RULE_16: Increment source: bit or pins zero-three.
// RULE_17: Decrement moves earlier, increment moves later.
// RULE_18: Feedback value 42 bits; low byte here.
// RULE_19: Software never programs feedback value zero.
// RULE_20: Software zeros unused low fractional bits.
// RULE_21: DPLL mode needs top two bits zero.
// RULE_22: Fields reset zero; reserved bits read zero.
// RULE_23: Pins synchronised before edge detection.

// Printed offsets are register indices; byte address is four times that.
`define APCFG_IDX_ENBYP 12'h100
`define APCFG_IDX_HSDIV 12'h101
`define APCFG_IDX_MUX 12'h102
`define APCFG_IDX_PHASE 12'h103
`define APCFG_IDX_FBDIV0 12'h106

// Writable bit masks; all other bits are reserved.
`define APCFG_MASK_ENBYP 8'h06
`define APCFG_MASK_HSDIV 8'hFF
`define APCFG_MASK_MUX 8'h7F
`define APCFG_MASK_PHASE 8'hFF
`define APCFG_MASK_FBDIV0 8'hFF
`define APCFG_RESET_VAL 8'h00

// Field positions.
`define APCFG_BIT_ENABLE 2
`define APCFG_BIT_BYPASS 1
`define APCFG_BIT_EXTERNAL_SWITCHING_MODE 6
`define APCFG_BIT_DECBIT 7
`define APCFG_BIT_INCBIT 3

// Input mux codes.
`define APCFG_SRC_XTAL 3'h0
`define APCFG_SRC_IN1 3'h1
`define APCFG_SRC_IN2 3'h2
`define APCFG_SRC_IN3 3'h3
`define APCFG_SRC_DPLL 3'h4

// Bypass feed codes; NONE means no bypass signal.
`define APCFG_BYP_XTAL 3'h0
`define APCFG_BYP_IN1 3'h1
`define APCFG_BYP_IN2 3'h2
`define APCFG_BYP_IN3 3'h3
`define APCFG_BYP_NONE 3'h7

`endif

/* apcfg_regs.v */
/*
 * Analog PLL configuration registers with APB slave, input source decode,
 * divider ratio decode and edge-driven phase stepping.
 * Assumes a synchronous APB master on mclk_i and general-purpose pins that
 * are asynchronous levels needing synchronisation.
 */
`include "apcfg_map.vh"

module apcfg_regs #(
   parameter GPIO_W = 4
) (
   input wire mclk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [13:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   input wire global_analog_pll_enable_i,
   input wire [GPIO_W-1:0] gpio_i,
   input wire [1:0] switch_pin_select_i,
   output reg second_divider_run_o,
   output reg output_bypass_select_o,
   output reg [4:0] second_divider_halves_o,
   output reg [4:0] first_divider_halves_o,
   output reg [2:0] apll_source_o,
   output reg [2:0] bypass_source_o,
   output reg dpll_power_down_ok_o,
   output reg phase_step_early_o,
   output reg phase_step_late_o,
   output reg [7:0] feedback_divide_byte0_o
);

   // Stored register contents.
   reg [7:0] enbyp_q;
   reg [7:0] hsdiv_q;
   reg [7:0] mux_q;
   reg [7:0] phase_q;
   reg [7:0] fbdiv0_q;
   // Two-stage pin synchronisers and the settled copy for edge detection.
   reg [GPIO_W-1:0] gpio_meta_q;
   reg [GPIO_W-1:0] gpio_sync_q;
   // Previous values of the selected step sources.
   reg dec_prev_q;
   reg inc_prev_q;
   // Read data register.
   reg [31:0] rdata_q;

   // Combinational helpers.
   wire [11:0] idx;
   wire addr_ok;
   wire wr_en;
   wire rd_en;
   wire [2:0] active_sel;
   wire switch_level;
   wire dec_src;
   wire inc_src;

   // Converts a divider code into a ratio counted in half steps.
   // Low codes are 4 to 7.5 in halves; high codes 8 to 15 whole.
   function [4:0] apcfg_div_halves;
      input [3:0] code;
      begin
         if (code[3]) begin
            apcfg_div_halves = {code[2:0] + 3'h0, 1'b0} + 5'h10;
         end else begin
            apcfg_div_halves = {2'h0, code[2:0]} + 5'h08;
         end
      end
   endfunction

   // Picks a step source: code 0 the register bit, 1 to 4 a pin.
   // Unused codes give a constant low, so they never make a step.
   function apcfg_step_src;
      input [2:0] sel;
      input bitval;
      input [GPIO_W-1:0] pins;
      begin
         case (sel)
            3'h0: apcfg_step_src = bitval;
            3'h1: apcfg_step_src = pins[0];
            3'h2: apcfg_step_src = pins[1];
            3'h3: apcfg_step_src = pins[2];
            3'h4: apcfg_step_src = pins[3];
            default: apcfg_step_src = 1'b0;
         endcase
      end
   endfunction

   // APB decode: byte address is four times the printed index.
   assign idx = paddr_i[13:2];
   assign addr_ok = (paddr_i[1:0] == 2'h0) &&
      (idx == `APCFG_IDX_ENBYP || idx == `APCFG_IDX_HSDIV ||
       idx == `APCFG_IDX_MUX || idx == `APCFG_IDX_PHASE ||
       idx == `APCFG_IDX_FBDIV0);
   assign wr_en = psel_i & penable_i & pwrite_i & addr_ok & pstrb_i[0];
   assign rd_en = psel_i & ~penable_i & ~pwrite_i;
   // Zero wait states; unmapped addresses answer with an error.
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_ok;
   assign prdata_o = rdata_q;

   // Register writes; reserved bits are masked so they stay zero.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         enbyp_q <= `APCFG_RESET_VAL; // RULE_22
         hsdiv_q <= `APCFG_RESET_VAL;
         mux_q <= `APCFG_RESET_VAL;
         phase_q <= `APCFG_RESET_VAL;
         fbdiv0_q <= `APCFG_RESET_VAL;
      end else if (wr_en) begin
         case (idx)
            `APCFG_IDX_ENBYP: begin
               enbyp_q <= pwdata_i[7:0] & `APCFG_MASK_ENBYP; // RULE_22
            end
            `APCFG_IDX_HSDIV: begin
               hsdiv_q <= pwdata_i[7:0] & `APCFG_MASK_HSDIV;
            end
            `APCFG_IDX_MUX: begin
               mux_q <= pwdata_i[7:0] & `APCFG_MASK_MUX; // RULE_22
            end
            `APCFG_IDX_PHASE: begin
               phase_q <= pwdata_i[7:0] & `APCFG_MASK_PHASE;
            end
            `APCFG_IDX_FBDIV0: begin
               // Zero value and unused fraction bits are software's duty.
               fbdiv0_q <= pwdata_i[7:0] & `APCFG_MASK_FBDIV0; // RULE_18
            end
            default: begin
               fbdiv0_q <= fbdiv0_q;
            end
         endcase
      end
   end

   // Read data is captured in the setup cycle so it is ready at access.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 32'h00000000;
      end else if (rd_en) begin
         case (idx)
            `APCFG_IDX_ENBYP: rdata_q <= {24'h000000, enbyp_q};
            `APCFG_IDX_HSDIV: rdata_q <= {24'h000000, hsdiv_q};
            `APCFG_IDX_MUX: rdata_q <= {24'h000000, mux_q};
            `APCFG_IDX_PHASE: rdata_q <= {24'h000000, phase_q};
            `APCFG_IDX_FBDIV0: rdata_q <= {24'h000000, fbdiv0_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end
   end

   // Pin synchroniser: the first stage feeds only the second.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         gpio_meta_q <= {GPIO_W{1'b0}};
         gpio_sync_q <= {GPIO_W{1'b0}};
      end else begin
         gpio_meta_q <= gpio_i; // RULE_23
         gpio_sync_q <= gpio_meta_q; // RULE_23
      end
   end

   // The switching pin is one of the synchronised general-purpose pins.
   assign switch_level = gpio_sync_q[switch_pin_select_i];
   // Alternate field counts only in external mode with the pin high.
   assign active_sel = (mux_q[`APCFG_BIT_EXTERNAL_SWITCHING_MODE] && switch_level) ?
      mux_q[5:3] : mux_q[2:0]; // RULE_05 RULE_06

   // Input source decode for the APLL and the bypass mux.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         apll_source_o <= `APCFG_SRC_XTAL;
         bypass_source_o <= `APCFG_BYP_XTAL;
         dpll_power_down_ok_o <= 1'b1;
      end else if (mux_q[`APCFG_BIT_EXTERNAL_SWITCHING_MODE] && switch_level) begin
         // Alternate codes drive both muxes; unused codes fall to crystal.
         case (mux_q[5:3]) // RULE_07
            3'h1: apll_source_o <= `APCFG_SRC_IN1;
            3'h2: apll_source_o <= `APCFG_SRC_IN2;
            3'h3: apll_source_o <= `APCFG_SRC_IN3;
            default: apll_source_o <= `APCFG_SRC_XTAL;
         endcase
         case (mux_q[5:3])
            3'h1: bypass_source_o <= `APCFG_BYP_IN1;
            3'h2: bypass_source_o <= `APCFG_BYP_IN2;
            3'h3: bypass_source_o <= `APCFG_BYP_IN3;
            default: bypass_source_o <= `APCFG_BYP_XTAL;
         endcase
         dpll_power_down_ok_o <= 1'b1;
      end else begin
         case (active_sel)
            3'h0: begin // RULE_08
               apll_source_o <= `APCFG_SRC_XTAL;
               bypass_source_o <= `APCFG_BYP_XTAL;
            end
            3'h1: begin // RULE_08
               apll_source_o <= `APCFG_SRC_IN1;
               bypass_source_o <= `APCFG_BYP_IN1;
            end
            3'h2: begin
               apll_source_o <= `APCFG_SRC_IN2;
               bypass_source_o <= `APCFG_BYP_IN2;
            end
            3'h3: begin
               apll_source_o <= `APCFG_SRC_IN3;
               bypass_source_o <= `APCFG_BYP_IN3;
            end
            3'h4: begin // RULE_11
               apll_source_o <= `APCFG_SRC_DPLL;
               bypass_source_o <= `APCFG_BYP_IN1;
            end
            3'h6: begin // RULE_09
               apll_source_o <= `APCFG_SRC_DPLL;
               bypass_source_o <= `APCFG_BYP_XTAL;
            end
            default: begin // RULE_09 RULE_11
               // Codes 5 and 7: nothing reaches the bypass mux, so
               // software must hold the bypass bit low. RULE_10
               apll_source_o <= `APCFG_SRC_DPLL;
               bypass_source_o <= `APCFG_BYP_NONE;
            end
         endcase
         // Direct feed lets the DPLL sleep.
         dpll_power_down_ok_o <= ~active_sel[2]; // RULE_12
      end
   end

   // Divider and bypass controls.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         second_divider_run_o <= 1'b0;
         output_bypass_select_o <= 1'b0;
         second_divider_halves_o <= 5'h08;
         first_divider_halves_o <= 5'h08;
         feedback_divide_byte0_o <= 8'h00;
      end else begin
         second_divider_run_o <= global_analog_pll_enable_i &
            enbyp_q[`APCFG_BIT_ENABLE] &
            ~enbyp_q[`APCFG_BIT_BYPASS]; // RULE_01
         output_bypass_select_o <= enbyp_q[`APCFG_BIT_BYPASS]; // RULE_02
         second_divider_halves_o <= apcfg_div_halves(hsdiv_q[7:4]); // RULE_03
         first_divider_halves_o <= apcfg_div_halves(hsdiv_q[3:0]); // RULE_04
         feedback_divide_byte0_o <= fbdiv0_q; // RULE_18
      end
   end

   // Selected step sources.
   assign dec_src = apcfg_step_src(phase_q[6:4],
      phase_q[`APCFG_BIT_DECBIT], gpio_sync_q); // RULE_14
   assign inc_src = apcfg_step_src(phase_q[2:0],
      phase_q[`APCFG_BIT_INCBIT], gpio_sync_q); // RULE_16

   // Either edge of a source makes one step pulse. A change of source
   // select with differing levels also looks like an edge; that is the
   // price of a single comparison and matches a real mux feeding an
   // edge detector.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dec_prev_q <= 1'b0;
         inc_prev_q <= 1'b0;
         phase_step_early_o <= 1'b0;
         phase_step_late_o <= 1'b0;
      end else begin
         dec_prev_q <= dec_src;
         inc_prev_q <= inc_src;
         // Decrement moves the clock earlier. RULE_17
         phase_step_early_o <= dec_src ^ dec_prev_q; // RULE_13
         // Increment moves the clock later. RULE_17
         phase_step_late_o <= inc_src ^ inc_prev_q; // RULE_15
      end
   end

endmodule

/* apcfg_asserts.sv */
/* Concurrent checks on the APLL configuration register block.
   Assumes one clock domain, mclk_i, and an active-high async reset. */
module apcfg_asserts #(
   parameter GPIO_W = 4
) (
   input wire mclk_i,
   input wire rst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [31:0] prdata_o,
   input wire global_analog_pll_enable_i,
   input wire [GPIO_W-1:0] gpio_i,
   input wire second_divider_run_o,
   input wire [4:0] second_divider_halves_o,
   input wire [4:0] first_divider_halves_o,
   input wire [2:0] apll_source_o,
   input wire [2:0] bypass_source_o,
   input wire dpll_power_down_ok_o,
   input wire phase_step_early_o,
   input wire phase_step_late_o,
   input wire [7:0] feedback_divide_byte0_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // A completed write access.
   wire wr_acc = psel_i & penable_i & pwrite_i;
   logic [GPIO_W-1:0] pin_q; // Pin levels one edge ago.
   logic [2:0] quiet_q; // Edges since the last pin change or write.
   // Steps may only follow a cause; the counter saturates so it never wraps.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_q <= '0;
         quiet_q <= 3'h0;
      end else begin
         pin_q <= gpio_i;
         if (wr_acc || gpio_i != pin_q) quiet_q <= 3'h0;
         else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
      end
   end
   property p_run;
      second_divider_run_o |-> $past(global_analog_pll_enable_i);
   endproperty
   a_run: assert property (p_run) else $error("divider runs while off");
   property p_div2;
      second_divider_halves_o >= 5'h08 &&
      (second_divider_halves_o < 5'h10 || !second_divider_halves_o[0]);
   endproperty
   a_div2: assert property (p_div2) else $error("bad divider two");
   property p_div1;
      first_divider_halves_o >= 5'h08 &&
      (first_divider_halves_o < 5'h10 || !first_divider_halves_o[0]);
   endproperty
   a_div1: assert property (p_div1) else $error("bad divider one");
   property p_src;
      apll_source_o <= 3'h4;
   endproperty
   a_src: assert property (p_src) else $error("bad apll source");
   property p_byp;
      bypass_source_o <= 3'h3 || bypass_source_o == 3'h7;
   endproperty
   a_byp: assert property (p_byp) else $error("bad bypass source");
   property p_dpll;
      dpll_power_down_ok_o == (apll_source_o != 3'h4);
   endproperty
   a_dpll: assert property (p_dpll) else $error("dpll flag wrong");
   property p_rd;
      prdata_o[31:8] == 24'h0;
   endproperty
   a_rd: assert property (p_rd) else $error("upper read bits set");
   property p_step;
      (phase_step_early_o || phase_step_late_o) |-> quiet_q < 3'h4;
   endproperty
   a_step: assert property (p_step) else $error("step without cause");
   property p_fb;
      $changed(feedback_divide_byte0_o) |-> $past(wr_acc) || $past(wr_acc, 2);
   endproperty
   a_fb: assert property (p_fb) else $error("feedback byte moved");
   c_early: cover property (phase_step_early_o);
   c_late: cover property (phase_step_late_o);
   c_run: cover property (second_divider_run_o);
endmodule

bind apcfg_regs apcfg_asserts #(.GPIO_W(GPIO_W)) chk_u (
   .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .prdata_o(prdata_o),
   .global_analog_pll_enable_i(global_analog_pll_enable_i),
   .gpio_i(gpio_i), .second_divider_run_o(second_divider_run_o),
   .second_divider_halves_o(second_divider_halves_o),
   .first_divider_halves_o(first_divider_halves_o),
   .apll_source_o(apll_source_o), .bypass_source_o(bypass_source_o),
   .dpll_power_down_ok_o(dpll_power_down_ok_o),
   .phase_step_early_o(phase_step_early_o),
   .phase_step_late_o(phase_step_late_o),
   .feedback_divide_byte0_o(feedback_divide_byte0_o));

/* apcfg_pins.sv */
/* Model of the general-purpose pins beside the block.
   Assumes the bench names the wanted levels; pins move after a clock edge. */
module apcfg_pins (
   input wire logic mclk_i,
   input wire logic [3:0] want_i,
   output logic [3:0] gpio_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial gpio_o = 4'h0;
   // Pins settle just after an edge, like board logic on the same clock.
   always @(posedge mclk_i) begin
      gpio_o <= want_i;
   end
endmodule

/* tb_apll_config_regs.sv */
/* Self-checking bench for the APLL configuration register block.
   Assumes the design's map header and APB with pready tied high. */
`include "apcfg_map.vh"
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   miscompares++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb_apll_config_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, glob = 0, er;
   logic [13:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [1:0] ssel = 0;
   logic [3:0] want = 0, gpio;
   wire [31:0] prdata;
   wire pready, perr, run, bsel, early, late, pdok;
   wire [4:0] h2, h1;
   wire [2:0] asrc, bsrc;
   wire [7:0] fb;
   int miscompares = 0, checks_done = 0, cyc_n = 0, ne = 0, nl = 0;
   logic [11:0] regs [5] = '{`APCFG_IDX_ENBYP, `APCFG_IDX_HSDIV,
      `APCFG_IDX_MUX, `APCFG_IDX_PHASE, `APCFG_IDX_FBDIV0};
   logic [7:0] msk [5] = '{`APCFG_MASK_ENBYP, `APCFG_MASK_HSDIV,
      `APCFG_MASK_MUX, `APCFG_MASK_PHASE, `APCFG_MASK_FBDIV0};
   logic [2:0] bx [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h1, 3'h7, 3'h0, 3'h7};
   apcfg_pins pins_u (.mclk_i(mclk_i), .want_i(want), .gpio_o(gpio));
   apcfg_regs dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(perr), .global_analog_pll_enable_i(glob), .gpio_i(gpio),
      .switch_pin_select_i(ssel), .second_divider_run_o(run),
      .output_bypass_select_o(bsel), .second_divider_halves_o(h2),
      .first_divider_halves_o(h1), .apll_source_o(asrc),
      .bypass_source_o(bsrc), .dpll_power_down_ok_o(pdok),
      .phase_step_early_o(early), .phase_step_late_o(late),
      .feedback_divide_byte0_o(fb));
   initial forever #50 mclk_i = ~mclk_i;
   // Count step pulses; a hang is cut short well past the expected run.
   always @(posedge mclk_i) begin
      if (early === 1'h1) ne++;
      if (late === 1'h1) nl++;
      cyc_n++;
      if (cyc_n == 5000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One APB transfer; holds the request until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] idx,
         input logic [7:0] d);
      @(posedge mclk_i);
      psel <= 1;
      pwr <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge mclk_i);
      pen <= 1;
      // Wait for ready at a rising edge; only the bench timeout ends it.
      do @(posedge mclk_i); while (pready !== 1'h1);
      rd = prdata;
      er = perr;
      psel <= 0;
      pen <= 0;
   endtask
   // Waits edges, then lets their updates land before sampling.
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   function automatic logic [4:0] hv(input int c);
      return (c < 8) ? 5'(c + 8) : 5'(c * 2);
   endfunction
   task automatic t_reset();
      for (int i = 0; i < 5; i++) begin
         apb(0, regs[i], 8'h00);
         `CK("reset value", 32'h0, rd)
      end
      apb(0, 12'h104, 8'h00);
      `CK("unmapped error", 1'h1, er)
      `CK("reset halves", 10'h108, {h2, h1})
      $display("test reset done");
   endtask
   task automatic t_regs();
      for (int i = 0; i < 5; i++) begin
         apb(1, regs[i], 8'hFF);
         apb(0, regs[i], 8'h00);
         `CK("read back", {24'h0, msk[i]}, rd)
         apb(1, regs[i], 8'h00);
      end
      apb(1, `APCFG_IDX_FBDIV0, 8'hA5);
      settle(2);
      `CK("feedback byte", 8'hA5, fb)
      for (int c = 0; c < 16; c++) begin
         apb(1, `APCFG_IDX_HSDIV, {4'(c), 4'(15 - c)});
         settle(2);
         `CK("divider two", hv(c), h2)
         `CK("divider one", hv(15 - c), h1)
      end
      $display("test registers done");
   endtask
   task automatic t_run();
      logic [2:0] k;
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         apb(1, `APCFG_IDX_ENBYP, {5'h0, k[1], k[0], 1'h0});
         glob <= k[2];
         settle(3);
         `CK("run", k[2] & k[1] & ~k[0], run)
         `CK("bypass", k[0], bsel)
      end
      apb(1, `APCFG_IDX_ENBYP, 8'h00);
      $display("test run done");
   endtask
   task automatic t_mux();
      ssel <= 2'h2;
      for (int c = 0; c < 8; c++) begin
         apb(1, `APCFG_IDX_MUX, 8'(c));
         settle(2);
         `CK("apll source", (c < 4) ? 3'(c) : 3'h4, asrc)
         `CK("bypass source", bx[c], bsrc)
         `CK("dpll off", c < 4, pdok)
      end
      apb(1, `APCFG_IDX_MUX, 8'h5E);
      settle(5);
      `CK("pin low", 3'h4, asrc)
      want = 4'h4;
      settle(5);
      `CK("pin high", 3'h3, asrc)
      apb(1, `APCFG_IDX_MUX, 8'h1E);
      settle(2);
      `CK("mode off", 3'h4, asrc)
      want = 4'h0;
      $display("test mux done");
   endtask
   task automatic t_phase();
      for (int s = 1; s < 5; s++) begin
         apb(1, `APCFG_IDX_PHASE, {1'h0, 3'(s), 1'h0, 3'(s)});
         settle(4);
         ne = 0; nl = 0;
         want[s - 1] = 1;
         settle(6);
         `CK("rise steps", 2'h2, 2'(ne + nl))
         want[s - 1] = 0;
         settle(6);
         `CK("fall steps", 2'h2, 2'(ne))
      end
      apb(1, `APCFG_IDX_PHASE, 8'h00);
      settle(4);
      ne = 0; nl = 0;
      apb(1, `APCFG_IDX_PHASE, 8'h80);
      settle(4);
      `CK("earlier", 4'h4, {2'(ne), 2'(nl)})
      apb(1, `APCFG_IDX_PHASE, 8'h08);
      settle(4);
      `CK("later", 4'h9, {2'(ne), 2'(nl)})
      $display("test phase done");
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_i <= 0;
      t_reset();
      t_regs();
      t_run();
      t_mux();
      t_phase();
      close_out();
   end
endmodule
